// ### rpsel_periph_model.sv
// Model of the peripherals and remappable pins around the pin select block
`timescale 1ns/1ps
module rpsel_periph_model (
   input wire logic clk,             // System clock
   output logic comparator1_output,  // Comparator one level
   output logic [121:2] remap_in,    // Input pin levels
   output logic [63:0] periph_out    // Output function levels
);
   // ==========
   // Rotating pattern, so that a late or stuck route shows up
   logic [127:0] pat_reg = 128'hF0E1D2C3B4A5968778695A4B3C2D1E0F;
   always @(posedge clk) pat_reg <= {pat_reg[126:0], pat_reg[127]};
   assign comparator1_output = pat_reg[1];
   assign remap_in = pat_reg[121:2];
   assign periph_out = pat_reg[127:64];
endmodule

// ### rpsel_pkg.sv
// Package of constants for the remappable pin select block
package rpsel_pkg;
   // ==================================================
   // Register map (word offsets chosen for this block)
   localparam logic [3:0] ADDR_IN_SEL = 4'h0;   // Input route register
   localparam logic [3:0] ADDR_OUT_SEL = 4'h1;  // Output route register
   localparam logic [3:0] ADDR_STATUS = 4'h2;   // Live routed SPI2 input and pin 38/39 output levels
   // ==================================================
   // Field positions
   localparam int CLK_SEL_LSB = 8;   // Clock source field low bit
   localparam int DAT_SEL_LSB = 0;   // Data source field low bit
   localparam int P39_SEL_LSB = 8;   // Pin 39 function field low bit
   localparam int P38_SEL_LSB = 0;   // Pin 38 function field low bit
   localparam int IN_SEL_W = 7;      // Input selection width
   localparam int OUT_SEL_W = 6;     // Output function width
   // ==================================================
   // Reset values and writable masks
   localparam logic [15:0] IN_SEL_RESET = 16'h0000;   // Input route reset
   localparam logic [15:0] OUT_SEL_RESET = 16'h0000;  // Output route reset
   localparam logic [15:0] IN_SEL_MASK = 16'h7F7F;    // Implemented input bits
   localparam logic [15:0] OUT_SEL_MASK = 16'h3F3F;   // Implemented output bits
   // ==================================================
   // Input source codes
   localparam logic [6:0] SRC_GROUND = 7'h00;  // Tied low
   localparam logic [6:0] SRC_COMPARATOR1_OUTPUT = 7'h01;    // Comparator one output
   localparam logic [6:0] SRC_MAX = 7'h79;     // Highest remappable input
endpackage

// ### rpsel_src_mux.sv
// Registered source selector for one peripheral input
`timescale 1ns/1ps
module rpsel_src_mux #(
   parameter int NSRC = 122   // Number of selectable codes
)(
   input wire logic clk,              // System clock
   input wire logic reset,            // Synchronous reset
   input wire logic [6:0] sel,        // Source code
   input wire logic [NSRC-1:0] srcs,  // Source levels by code
   output logic q                     // Registered routed level
);
   logic q_next;  // Selected level
   initial
   begin
      if (NSRC < 2 || NSRC > 128)
         $error("NSRC out of range");
   end
   // Pick source, out of range codes read ground
   always_comb
   begin
      q_next = 1'b0;
      if (32'(sel) < NSRC)
         q_next = srcs[sel];
   end
   // Register the routed level
   always_ff @(posedge clk)
   begin
      if (reset)
         q <= 1'b0;
      else
         q <= q_next;
   end
endmodule

// ### rpsel_top.sv
// Remappable pin select: SPI2 input routing and pin 38/39 output routing
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// R1: Bits 14-8 pick SPI2 clock source
// R2: Bits 6-0 pick SPI2 data source
// R3: Code 0 ground, 1 comparator, up to pin 121
// R4: Bits 5-0 pick pin 38 function
// R5: Bits 13-8 pick pin 39 function
// R6: Unused register bits read as zero
// R7: New selection applies next cycle after write
module rpsel_top #(
   parameter int NFUNC = 64   // Peripheral output functions
)(
   input wire logic clk,                     // System clock
   input wire logic reset,                   // Synchronous reset, active high
   input wire logic [3:0] addr,              // Register word address
   input wire logic [15:0] wdata,            // Write data
   input wire logic wr,                      // Write strobe
   input wire logic rd,                      // Read strobe
   output logic [15:0] rdata,                // Read data, cycle after read
   input wire logic comparator1_output,      // Comparator one level
   input wire logic [121:2] remap_in,        // Remappable input pins by number
   input wire logic [NFUNC-1:0] periph_out,  // Peripheral output functions by number
   output logic spi2_clock_in,               // Routed SPI2 clock input
   output logic spi2_data_in,                // Routed SPI2 data input
   output logic pin38_out,                   // Remappable pin 38 drive
   output logic pin39_out                    // Remappable pin 39 drive
);
   // ==================================================
   // Registers
   logic [15:0] in_sel_reg, in_sel_next;    // Input route register
   logic [15:0] out_sel_reg, out_sel_next;  // Output route register
   logic [15:0] rdata_next;                 // Read data next
   logic pin38_next, pin39_next;            // Output pin levels next
   logic [5:0] f38, f39;                    // Function numbers
   logic [127:0] srcs;                      // Input source vector
   initial
   begin
      if (NFUNC < 1 || NFUNC > 64)
         $error("NFUNC out of range");
   end
   // Register write decode, masked so unused bits stay zero
   always_comb
   begin
      in_sel_next = in_sel_reg;
      out_sel_next = out_sel_reg;
      if (wr && addr == rpsel_pkg::ADDR_IN_SEL)
         in_sel_next = wdata & rpsel_pkg::IN_SEL_MASK;  // [R1] [R2] [R6]
      if (wr && addr == rpsel_pkg::ADDR_OUT_SEL)
         out_sel_next = wdata & rpsel_pkg::OUT_SEL_MASK;  // [R4] [R5] [R6]
   end
   // Read mux, unmapped reads zero
   always_comb
   begin
      rdata_next = 16'h0000;
      if (rd)
      begin
         case (addr)
            rpsel_pkg::ADDR_IN_SEL: rdata_next = in_sel_reg;  // [R6]
            rpsel_pkg::ADDR_OUT_SEL: rdata_next = out_sel_reg;  // [R6]
            rpsel_pkg::ADDR_STATUS:
               rdata_next = {12'h000, pin39_out, pin38_out, spi2_data_in, spi2_clock_in};
            default: rdata_next = 16'h0000;
         endcase
      end
   end
   // Register state
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         in_sel_reg <= rpsel_pkg::IN_SEL_RESET;
         out_sel_reg <= rpsel_pkg::OUT_SEL_RESET;
         rdata <= 16'h0000;
         pin38_out <= 1'b0;
         pin39_out <= 1'b0;
      end
      else
      begin
         in_sel_reg <= in_sel_next;
         out_sel_reg <= out_sel_next;
         rdata <= rdata_next;
         pin38_out <= pin38_next;
         pin39_out <= pin39_next;
      end
   end
   // ==================================================
   // Input routing: code 0 ground, 1 comparator, 2..121 pins
   assign srcs = {6'h00, remap_in, comparator1_output, 1'b0};  // [R3]
   rpsel_src_mux #(.NSRC(122)) u_clk_mux (
      .clk(clk),
      .reset(reset),
      .sel(in_sel_reg[rpsel_pkg::CLK_SEL_LSB +: rpsel_pkg::IN_SEL_W]),  // [R1] [R7]
      .srcs(srcs[121:0]),
      .q(spi2_clock_in)
   );
   rpsel_src_mux #(.NSRC(122)) u_dat_mux (
      .clk(clk),
      .reset(reset),
      .sel(in_sel_reg[rpsel_pkg::DAT_SEL_LSB +: rpsel_pkg::IN_SEL_W]),  // [R2] [R7]
      .srcs(srcs[121:0]),
      .q(spi2_data_in)
   );
   // ==================================================
   // Output routing: function 0 drives low
   assign f38 = out_sel_reg[rpsel_pkg::P38_SEL_LSB +: rpsel_pkg::OUT_SEL_W];  // [R4]
   assign f39 = out_sel_reg[rpsel_pkg::P39_SEL_LSB +: rpsel_pkg::OUT_SEL_W];  // [R5]
   always_comb
   begin
      pin38_next = 1'b0;
      pin39_next = 1'b0;
      if (f38 != 6'h00 && 32'(f38) < NFUNC)
         pin38_next = periph_out[f38];  // [R4] [R7]
      if (f39 != 6'h00 && 32'(f39) < NFUNC)
         pin39_next = periph_out[f39];  // [R5] [R7]
   end
   // ==================================================
   // Checks: register contents

   // Input route never holds an unused bit
   a_in_unused_zero: assert property (@(posedge clk) disable iff (reset)
      (in_sel_reg & ~rpsel_pkg::IN_SEL_MASK) == 16'h0000)  // [R6]
      else $error("input route unused bits set");

   // Output route never holds an unused bit
   a_out_unused_zero: assert property (@(posedge clk) disable iff (reset)
      (out_sel_reg & ~rpsel_pkg::OUT_SEL_MASK) == 16'h0000)  // [R6]
      else $error("output route unused bits set");

   // Input route write lands, masked
   a_in_write_takes: assert property (@(posedge clk) disable iff (reset)
      wr && addr == rpsel_pkg::ADDR_IN_SEL |=>
      in_sel_reg == ($past(wdata) & rpsel_pkg::IN_SEL_MASK))  // [R1]
      else $error("input route write lost");

   // Output route write lands, masked
   a_out_write_takes: assert property (@(posedge clk) disable iff (reset)
      wr && addr == rpsel_pkg::ADDR_OUT_SEL |=>
      out_sel_reg == ($past(wdata) & rpsel_pkg::OUT_SEL_MASK))  // [R4]
      else $error("output route write lost");

   // Input route holds without a write to it
   a_in_sel_holds: assert property (@(posedge clk) disable iff (reset)
      !(wr && addr == rpsel_pkg::ADDR_IN_SEL) |=> $stable(in_sel_reg))  // [R7]
      else $error("input route changed without write");

   // Output route holds without a write to it
   a_out_sel_holds: assert property (@(posedge clk) disable iff (reset)
      !(wr && addr == rpsel_pkg::ADDR_OUT_SEL) |=> $stable(out_sel_reg))  // [R7]
      else $error("output route changed without write");

   // Reset clears registers and every output
   a_reset_quiet: assert property (@(posedge clk)
      reset |=> rdata == 16'h0000 && in_sel_reg == 16'h0000 && out_sel_reg == 16'h0000
      && !spi2_clock_in && !spi2_data_in && !pin38_out && !pin39_out)  // [R6]
      else $error("reset left state set");

   // ==================================================
   // Checks: register reads

   // No read strobe gives zero read data
   a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
      !rd |=> rdata == 16'h0000)  // [R6]
      else $error("read data without strobe");

   // Input route reads back
   a_read_in_sel: assert property (@(posedge clk) disable iff (reset)
      rd && addr == rpsel_pkg::ADDR_IN_SEL |=> rdata == $past(in_sel_reg))  // [R6]
      else $error("input route read wrong");

   // Output route reads back
   a_read_out_sel: assert property (@(posedge clk) disable iff (reset)
      rd && addr == rpsel_pkg::ADDR_OUT_SEL |=> rdata == $past(out_sel_reg))  // [R6]
      else $error("output route read wrong");

   // Status shows routed levels at the read edge
   a_read_status: assert property (@(posedge clk) disable iff (reset)
      rd && addr == rpsel_pkg::ADDR_STATUS |=>
      rdata == {12'h000, $past(pin39_out), $past(pin38_out), $past(spi2_data_in),
      $past(spi2_clock_in)})  // [R6]
      else $error("status read wrong");

   // ==================================================
   // Checks: input routing

   // Clock code 0 drives ground
   a_clk_ground: assert property (@(posedge clk) disable iff (reset)
      in_sel_reg[14:8] == 7'h00 |=> !spi2_clock_in)  // [R3]
      else $error("ground source not low");

   // Data code 0 drives ground
   a_dat_ground: assert property (@(posedge clk) disable iff (reset)
      in_sel_reg[6:0] == 7'h00 |=> !spi2_data_in)  // [R3]
      else $error("data ground source not low");

   // Data code 1 follows the comparator
   a_dat_cmp: assert property (@(posedge clk) disable iff (reset)
      in_sel_reg[6:0] == 7'h01 |=> spi2_data_in == $past(comparator1_output))  // [R3]
      else $error("comparator source wrong");

   // Clock code 1 follows the comparator
   a_clk_cmp: assert property (@(posedge clk) disable iff (reset)
      in_sel_reg[14:8] == 7'h01 |=> spi2_clock_in == $past(comparator1_output))  // [R3]
      else $error("clock comparator source wrong");

   // Clock top code follows pin 121
   a_clk_pin121: assert property (@(posedge clk) disable iff (reset)
      in_sel_reg[14:8] == 7'h79 |=> spi2_clock_in == $past(remap_in[121]))  // [R3]
      else $error("pin 121 source wrong");

   // Data top code follows pin 121
   a_dat_pin121: assert property (@(posedge clk) disable iff (reset)
      in_sel_reg[6:0] == 7'h79 |=> spi2_data_in == $past(remap_in[121]))  // [R3]
      else $error("data pin 121 source wrong");

   // Clock codes past the last pin read ground
   a_clk_beyond: assert property (@(posedge clk) disable iff (reset)
      in_sel_reg[14:8] > rpsel_pkg::SRC_MAX |=> !spi2_clock_in)  // [R3]
      else $error("unused clock code not low");

   // ==================================================
   // Checks: output routing

   // Pin 38 follows function 1
   a_pin38_route: assert property (@(posedge clk) disable iff (reset)
      f38 == 6'h01 |=> pin38_out == $past(periph_out[1]))  // [R4]
      else $error("pin 38 routing wrong");

   // Pin 39 follows function 2
   a_pin39_route: assert property (@(posedge clk) disable iff (reset)
      f39 == 6'h02 |=> pin39_out == $past(periph_out[2]))  // [R5]
      else $error("pin 39 routing wrong");

   // Function 0 drives pin 38 low
   a_pin38_off: assert property (@(posedge clk) disable iff (reset)
      f38 == 6'h00 |=> !pin38_out)  // [R4]
      else $error("pin 38 not low");

   // Function 0 drives pin 39 low
   a_pin39_off: assert property (@(posedge clk) disable iff (reset)
      f39 == 6'h00 |=> !pin39_out)  // [R5]
      else $error("pin 39 not low");

   // A written function 0 drives pin 38 low two edges on
   a_write_applies: assert property (@(posedge clk) disable iff (reset)
      wr && addr == rpsel_pkg::ADDR_OUT_SEL && wdata[5:0] == 6'h00 ##1 !wr |=> !pin38_out)  // [R7]
      else $error("new selection not applied");
endmodule

// ### tb_top.sv
// Self-checking testbench for the remappable pin select block
`timescale 1ns/1ps
module tb_top;
   // ==========
   // Stimulus and observed signals
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic cmp;
   logic [121:2] pins;
   logic [63:0] funcs;
   logic sck, sdi, p38, p39;
   int num_errors = 0;
   int comparisons = 0;
   always #12.5 clk = ~clk;
   rpsel_periph_model i_model (.clk(clk), .comparator1_output(cmp), .remap_in(pins),
      .periph_out(funcs));
   rpsel_top i_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .comparator1_output(cmp), .remap_in(pins), .periph_out(funcs),
      .spi2_clock_in(sck), .spi2_data_in(sdi), .pin38_out(p38), .pin39_out(p39));
   // ==========
   // Expected levels of sources
   function automatic logic in_lvl(logic [6:0] c);
      if (c == rpsel_pkg::SRC_COMPARATOR1_OUTPUT) return cmp;
      if (c == rpsel_pkg::SRC_GROUND || c > rpsel_pkg::SRC_MAX) return 1'b0;
      return pins[c];
   endfunction
   function automatic logic out_lvl(logic [5:0] f);
      return (f == 6'h00) ? 1'b0 : funcs[f];
   endfunction
   // ==========
   // Shared tasks
   task automatic check(logic [15:0] seen, logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(logic [3:0] a, logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_check(logic [3:0] a, logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check(rdata, exp);
   endtask
   task automatic route(logic [6:0] c, logic [6:0] d, logic [5:0] f8, logic [5:0] f9);
      logic [3:0] exp;
      wr_reg(rpsel_pkg::ADDR_IN_SEL, {1'b0, c, 1'b0, d});
      wr_reg(rpsel_pkg::ADDR_OUT_SEL, {2'b00, f9, 2'b00, f8});
      @(negedge clk);
      exp = {in_lvl(c), in_lvl(d), out_lvl(f8), out_lvl(f9)};
      repeat (4)
      begin
         @(negedge clk);
         check({12'h000, sck, sdi, p38, p39}, {12'h000, exp});
         exp = {in_lvl(c), in_lvl(d), out_lvl(f8), out_lvl(f9)};
      end
   endtask
   task automatic status_check;
      logic [15:0] exp;
      @(posedge clk);
      addr <= rpsel_pkg::ADDR_STATUS;
      rd <= 1'b1;
      @(negedge clk);
      exp = {12'h000, p39, p38, sdi, sck};
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check(rdata, exp);
   endtask
   task automatic tally_and_finish;
      if (num_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ==========
   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rd_check(rpsel_pkg::ADDR_IN_SEL, 16'h0000);
      rd_check(rpsel_pkg::ADDR_OUT_SEL, 16'h0000);
      wr_reg(rpsel_pkg::ADDR_IN_SEL, 16'hFFFF);
      rd_check(rpsel_pkg::ADDR_IN_SEL, 16'h7F7F);
      wr_reg(rpsel_pkg::ADDR_OUT_SEL, 16'hFFFF);
      rd_check(rpsel_pkg::ADDR_OUT_SEL, 16'h3F3F);
      wr_reg(4'h3, 16'hFFFF);
      rd_check(4'h3, 16'h0000);
      route(7'h00, 7'h01, 6'h00, 6'h01);
      route(7'h01, 7'h00, 6'h3F, 6'h00);
      route(7'h02, 7'h79, 6'h15, 6'h2A);
      route(7'h79, 7'h3C, 6'h01, 6'h3F);
      route(7'h7F, 7'h7A, 6'h20, 6'h07);
      route(7'h3C, 7'h02, 6'h00, 6'h02);
      status_check;
      tally_and_finish;
   end
   // Watchdog against a hang
   initial
   begin
      repeat (2000) @(posedge clk);
      num_errors++;
      tally_and_finish;
   end
endmodule
